// file: lss_pkg.sv
// constants, register map and types of the level sweep sequencer
package lss_pkg;
   localparam int          LSS_LVL_W      = 16;  // level, signed 0.01 dB
   localparam int          LSS_DW_W       = 32;  // dwell count width
   localparam int          LSS_ADDR_W     = 8;   // register address width
   // register byte offsets
   localparam logic [7:0]  LSS_REG_CTRL   = 8'h00;
   localparam logic [7:0]  LSS_REG_START  = 8'h04;
   localparam logic [7:0]  LSS_REG_STOP   = 8'h08;
   localparam logic [7:0]  LSS_REG_STEP   = 8'h0C;
   localparam logic [7:0]  LSS_REG_DWELL  = 8'h10;
   localparam logic [7:0]  LSS_REG_CUR    = 8'h14;
   localparam logic [7:0]  LSS_REG_CMD    = 8'h18;
   localparam logic [7:0]  LSS_REG_STAT   = 8'h1C;
   // control field positions
   localparam int          LSS_EN_BIT     = 0;
   localparam int          LSS_MODE_LSB   = 1;
   localparam int          LSS_SHAPE_BIT  = 4;
   localparam int          LSS_SLOPE_BIT  = 5;
   localparam int          LSS_REMOTE_BIT = 6;
   localparam int          LSS_FSW_BIT    = 7;
   localparam int          LSS_LIST_BIT   = 8;
   // command field positions
   localparam int          LSS_CMD_RST    = 0;
   localparam int          LSS_CMD_EXEC   = 1;
   // reset values
   localparam logic [15:0] LSS_RST_START  = 16'hF830; // -20.00 dB
   localparam logic [15:0] LSS_RST_STOP   = 16'h0000; // 0.00 dB
   localparam logic [15:0] LSS_RST_STEP   = 16'h0064; // 1.00 dB
   localparam logic [31:0] LSS_RST_DWELL  = 32'h0000_07D0;
   // settling interval at the start of each step
   localparam int          LSS_CLK_MHZ    = 200;
   localparam int          LSS_SETTLE_NS  = 100;
   localparam int          LSS_SETTLE_CYC =
      (LSS_SETTLE_NS * LSS_CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {
      LSS_MODE_AUTO    = 3'h0,
      LSS_MODE_SINGLE  = 3'h1,
      LSS_MODE_STEP    = 3'h2,
      LSS_MODE_XSINGLE = 3'h3,
      LSS_MODE_XSTEP   = 3'h4,
      LSS_MODE_XSS     = 3'h5
   } lss_mode_t;
   typedef enum logic [2:0] {
      LSS_ST_IDLE = 3'b001,
      LSS_ST_RUN  = 3'b010,
      LSS_ST_HOLD = 3'b100
   } lss_state_t;
endpackage : lss_pkg

// file: lss_tmr_if.sv
// interface between the sequencer core and its dwell timer
`timescale 1ns/1ps
interface lss_tmr_if;
   logic        load;    // start a new step period
   logic [31:0] dwell;   // step period in clocks
   logic        tick;    // step period over
   logic        settled; // settling interval passed
   modport ctl (output load, output dwell, input tick, input settled);
   modport tmr (input load, input dwell, output tick, output settled);
endinterface : lss_tmr_if

// file: lss_trig_edge.sv
// active edge detector for the external trigger input
`timescale 1ns/1ps
module lss_trig_edge (
   input  wire logic clk_sys,  // system clock
   input  wire logic rst,      // async reset, active high
   input  wire logic trig_in,  // trigger pin level
   input  wire logic neg,      // 1: falling edge is active
   output logic      edge_hit  // one-cycle pulse per active edge
);
   logic prev_q;   // last sampled level
   logic valid_q;  // prev_q holds a real sample
   // sample the pin; first sample after reset arms the detector only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_q  <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         prev_q  <= trig_in;
         valid_q <= 1'b1;
      end
   end
   // polarity select keeps one detector for both slopes
   assign edge_hit = valid_q & (neg ? (prev_q & ~trig_in)
                                    : (~prev_q & trig_in));
endmodule : lss_trig_edge

// file: lss_dwell_timer.sv
// dwell timer: one period per step, with a settled flag
`timescale 1ns/1ps
module lss_dwell_timer
   import lss_pkg::*;
(
   input  wire logic clk_sys,  // system clock
   input  wire logic rst,      // async reset, active high
   lss_tmr_if.tmr    t         // timer side of the carrier
);
   logic [31:0] elap_q;  // clocks since load
   logic [31:0] per_q;   // latched period
   logic        run_q;   // period in progress
   logic        last_w;  // final clock of the period
   assign last_w = run_q & ((elap_q + 32'h1) >= per_q);
   // count one period; a period below two clocks is stretched to two
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         elap_q <= 32'h0;
         per_q  <= 32'h2;
         run_q  <= 1'b0;
      end else if (t.load) begin
         elap_q <= 32'h0;
         per_q  <= (t.dwell < 32'h2) ? 32'h2 : t.dwell;
         run_q  <= 1'b1;
      end else if (run_q) begin
         elap_q <= elap_q + 32'h1;
         run_q  <= ~last_w;
      end
   end
   assign t.tick    = last_w;
   assign t.settled = elap_q >= 32'(LSS_SETTLE_CYC);
endmodule : lss_dwell_timer

// file: lss_core.sv
// level sweep sequencer: register port, sweep state machine, level output
// Function
// - mode change halts; next trigger restarts
// - reset loads start level as current
// - auto mode repeats cycles without trigger
// - single mode: one cycle per execute
// - manual step: each level write steps once
// - entering step mode stops, keeps level
// - remote step: write only steps toward stop
// - external single: edge runs one cycle
// - external step: one step per edge
// - edges start, hold, then restart sweep
// - execute accepted only in single mode
// - sawtooth: start to stop, restart
// - triangle: up to stop, back down
// - every step but the sawtooth return to start moves by step width, the last one clamped to the end level
// - each step lasts one dwell time
// - trigger slope selects rising or falling
// - current level readable, next-step level
// - level sweep disables frequency sweep, list
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module lss_core
   import lss_pkg::*;
(
   input  wire logic        clk_sys,       // system clock, 200 MHz
   input  wire logic        rst,           // async reset, active high
   input  wire logic [7:0]  reg_addr,      // register byte address
   input  wire logic [31:0] reg_wdata,     // register write data
   input  wire logic        reg_wr,        // write strobe
   input  wire logic        reg_rd,        // read strobe
   output logic      [31:0] reg_rdata,     // read data, cycle after rd
   input  wire logic        external_trigger_input, // trigger pin
   output logic      [15:0] level_out,     // applied level, 0.01 dB
   output logic             level_settled, // step past settling
   output logic             sweep_active,  // sweep running
   output logic             freq_sweep_en, // frequency sweep enable
   output logic             list_en        // list sequencing enable
);
   // ---------------- configuration registers ----------------
   logic            en_q;       // level sweep enabled
   lss_mode_t       mode_q;     // sweep mode
   logic            tri_q;      // 1: triangle, 0: sawtooth
   logic            neg_q;      // 1: falling trigger edge
   logic            remote_q;   // step mode driven remotely
   logic            fsw_q;      // frequency sweep enable
   logic            list_q;     // list sequencing enable
   logic [15:0]     start_q;    // start level
   logic [15:0]     stop_q;     // stop level
   logic [15:0]     step_q;     // step width
   logic [31:0]     dwell_q;    // dwell in clocks
   // ---------------- sweep state ----------------
   lss_state_t      state_q;    // sequencer state
   lss_state_t      state_d;
   logic [15:0]     level_q;    // level applied
   logic [15:0]     level_d;
   logic            desc_q;     // on falling leg of a triangle
   logic            desc_d;
   // a halted sweep must not resume mid-range on the next external step
   logic            restart_q;  // next external step loads start level
   logic            restart_d;
   logic [31:0]     rdata_d;    // read mux result
   lss_tmr_if       tmr ();     // carrier to the dwell timer
   logic            edge_w;     // active trigger edge

   // signed step of one width toward a target, stopping on it
   function automatic logic [15:0] step_toward(input logic [15:0] cur,
                                               input logic [15:0] stp,
                                               input logic [15:0] tgt);
      logic signed [16:0] c;
      logic signed [16:0] t;
      logic signed [16:0] s;
      logic signed [16:0] n;
      c = {cur[15], cur};
      t = {tgt[15], tgt};
      s = {1'b0, stp};
      if (t >= c) begin
         n = c + s;
         if (n > t) n = t;
      end else begin
         n = c - s;
         if (n < t) n = t;
      end
      return n[15:0];
   endfunction : step_toward

   // ---------------- submodules ----------------
   lss_trig_edge u_edge (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .trig_in  (external_trigger_input),
      .neg      (neg_q),
      .edge_hit (edge_w)
   );
   lss_dwell_timer u_tmr (
      .clk_sys (clk_sys),
      .rst     (rst),
      .t       (tmr.tmr)
   );

   // ---------------- register decode ----------------
   wire wr_ctrl  = reg_wr & (reg_addr == LSS_REG_CTRL);
   wire wr_start = reg_wr & (reg_addr == LSS_REG_START);
   wire wr_stop  = reg_wr & (reg_addr == LSS_REG_STOP);
   wire wr_step  = reg_wr & (reg_addr == LSS_REG_STEP);
   wire wr_dwell = reg_wr & (reg_addr == LSS_REG_DWELL);
   wire wr_cur   = reg_wr & (reg_addr == LSS_REG_CUR);
   wire wr_cmd   = reg_wr & (reg_addr == LSS_REG_CMD);
   wire [2:0] new_mode_w = reg_wdata[LSS_MODE_LSB +: 3];
   wire new_en_w  = reg_wdata[LSS_EN_BIT];
   // mode or enable change stops whatever is running
   wire mode_chg_w = wr_ctrl & ((new_mode_w != mode_q) | (new_en_w != en_q));
   wire sw_reset_w = wr_cmd & reg_wdata[LSS_CMD_RST];
   // execute is honoured only in single mode, ignored otherwise
   wire exec_w = wr_cmd & reg_wdata[LSS_CMD_EXEC]
                 & (mode_q == LSS_MODE_SINGLE);

   // ---------------- sweep arithmetic ----------------
   wire [15:0] tgt_w     = desc_q ? start_q : stop_q;
   wire [15:0] nxt_w     = step_toward(level_q, step_q, tgt_w);
   wire [15:0] down_w    = step_toward(level_q, step_q, start_q);
   wire [15:0] up_w      = step_toward(level_q, step_q, stop_q);
   wire        at_end_w  = (level_q == tgt_w);
   // end of cycle: stop reached on sawtooth, start reached on way down
   wire        cyc_end_w = at_end_w & (~tri_q | desc_q);
   wire        turn_w    = at_end_w & tri_q & ~desc_q;
   wire        repeat_w  = (mode_q == LSS_MODE_AUTO) |
                           (mode_q == LSS_MODE_XSS);
   // next level after a timed or triggered step; a triangle that is back
   // at start climbs at once, so start is not held for two dwells
   wire [15:0] adv_lvl_w = ~at_end_w ? nxt_w :
                           (turn_w ? down_w :
                           (tri_q ? up_w : start_q));
   wire        adv_desc_w = turn_w ? 1'b1 : (cyc_end_w ? 1'b0 : desc_q);

   // manual step target: entered level, or stop when remote
   wire [15:0] man_tgt_w = remote_q ? stop_q
                                    : reg_wdata[15:0];
   wire [15:0] man_lvl_w = step_toward(level_q, step_q, man_tgt_w);

   // cycle start requests for the timed modes
   wire start_req_w = en_q & (
        ((mode_q == LSS_MODE_AUTO) & (state_q == LSS_ST_IDLE))
      | exec_w
      | ((mode_q == LSS_MODE_XSINGLE) & edge_w));
   wire xstep_w = en_q & (mode_q == LSS_MODE_XSTEP) & edge_w;
   wire mstep_w = en_q & (mode_q == LSS_MODE_STEP) & wr_cur;
   wire xss_w   = en_q & (mode_q == LSS_MODE_XSS) & edge_w;

   // ---------------- state machine ----------------
   always_comb begin
      state_d  = state_q;
      level_d  = level_q;
      desc_d   = desc_q;
      restart_d = restart_q;
      tmr.load = 1'b0;
      if (mode_chg_w) begin
         // halt; next trigger begins again at start level
         state_d = LSS_ST_IDLE;
         restart_d = 1'b1;
         desc_d  = 1'b0;
      end else if (sw_reset_w) begin
         // start level becomes current, next sweep runs from it
         state_d = LSS_ST_IDLE;
         level_d = start_q;
         desc_d  = 1'b0;
      end else if (mstep_w) begin
         // stepping continues from whatever level is applied
         level_d = man_lvl_w;
      end else if (xstep_w) begin
         level_d   = restart_q ? start_q : adv_lvl_w;
         desc_d    = restart_q ? 1'b0 : adv_desc_w;
         restart_d = 1'b0;
      end else begin
         unique case (state_q)
            LSS_ST_IDLE: begin
               if (start_req_w | xss_w) begin
                  state_d  = LSS_ST_RUN;
                  level_d  = start_q;
                  desc_d   = 1'b0;
                  tmr.load = 1'b1;
               end
            end
            LSS_ST_RUN: begin
               if (xss_w) begin
                  state_d = LSS_ST_HOLD;
               end else if (tmr.tick) begin
                  if (cyc_end_w & ~repeat_w) begin
                     // single cycle done: hold last level, idle
                     state_d = LSS_ST_IDLE;
                  end else begin
                     level_d  = adv_lvl_w;
                     desc_d   = adv_desc_w;
                     tmr.load = 1'b1;
                  end
               end
            end
            LSS_ST_HOLD: begin
               if (xss_w) begin
                  // third edge: restart from the start level
                  state_d  = LSS_ST_RUN;
                  level_d  = start_q;
                  desc_d   = 1'b0;
                  tmr.load = 1'b1;
               end
            end
            default: begin
               state_d = LSS_ST_IDLE;
            end
         endcase
      end
   end
   assign tmr.dwell = dwell_q;

   // sequencer state registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= LSS_ST_IDLE;
         level_q <= LSS_RST_START;
         desc_q  <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         state_q <= state_d;
         level_q <= level_d;
         desc_q  <= desc_d;
         restart_q <= restart_d;
      end
   end

   // ---------------- control register ----------------
   // enabling the level sweep clears the other sweep and list enables;
   // the level sweep wins if software sets several at once
   wire       fsw_w  = reg_wdata[LSS_FSW_BIT] & ~new_en_w;
   wire       list_w = reg_wdata[LSS_LIST_BIT] & ~new_en_w;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         en_q     <= 1'b0;
         mode_q   <= LSS_MODE_AUTO;
         tri_q    <= 1'b0;
         neg_q    <= 1'b0;
         remote_q <= 1'b0;
         fsw_q    <= 1'b0;
         list_q   <= 1'b0;
      end else if (wr_ctrl) begin
         en_q     <= new_en_w;
         mode_q   <= lss_mode_t'(new_mode_w);
         tri_q    <= reg_wdata[LSS_SHAPE_BIT];
         neg_q    <= reg_wdata[LSS_SLOPE_BIT];
         remote_q <= reg_wdata[LSS_REMOTE_BIT];
         fsw_q    <= fsw_w;
         list_q   <= list_w;
      end
   end

   // ---------------- range, step and dwell registers ----------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         start_q <= LSS_RST_START;
         stop_q  <= LSS_RST_STOP;
         step_q  <= LSS_RST_STEP;
         dwell_q <= LSS_RST_DWELL;
      end else begin
         if (wr_start) start_q <= reg_wdata[15:0];
         if (wr_stop)  stop_q  <= reg_wdata[15:0];
         if (wr_step)  step_q  <= reg_wdata[15:0];
         if (wr_dwell) dwell_q <= reg_wdata;
      end
   end

   // ---------------- read path ----------------
   // a level read returns the applied level, which in step mode is
   // also the level the next step starts from
   wire [31:0] ctrl_rd_w = {23'h0, list_q, fsw_q, remote_q, neg_q,
                            tri_q, mode_q, en_q};
   wire [31:0] stat_rd_w = {28'h0, level_settled, desc_q,
                            state_q == LSS_ST_HOLD,
                            state_q == LSS_ST_RUN};
   always_comb begin
      unique case (reg_addr)
         LSS_REG_CTRL:  rdata_d = ctrl_rd_w;
         LSS_REG_START: rdata_d = {16'h0, start_q};
         LSS_REG_STOP:  rdata_d = {16'h0, stop_q};
         LSS_REG_STEP:  rdata_d = {16'h0, step_q};
         LSS_REG_DWELL: rdata_d = dwell_q;
         LSS_REG_CUR:   rdata_d = {16'h0, level_q};
         LSS_REG_STAT:  rdata_d = stat_rd_w;
         default:       rdata_d = 32'h0;  // unmapped and command read 0
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : 32'h0;
      end
   end

   // ---------------- registered outputs ----------------
   // the timer gates settled only while a timed step is running; manual levels are
   // taken as settled since no timer watches them
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         level_out     <= LSS_RST_START;
         level_settled <= 1'b0;
         sweep_active  <= 1'b0;
         freq_sweep_en <= 1'b0;
         list_en       <= 1'b0;
      end else begin
         level_out     <= level_d;
         level_settled <= (state_q != LSS_ST_RUN) | tmr.settled;
         sweep_active  <= state_d == LSS_ST_RUN;
         freq_sweep_en <= wr_ctrl ? fsw_w : fsw_q;
         list_en       <= wr_ctrl ? list_w : list_q;
      end
   end
endmodule : lss_core

// file: lss_monitor.sv
// port-level checks for the level sweep sequencer
`timescale 1ns/1ps
module lss_monitor
   import lss_pkg::*;
(
   input wire logic        clk_sys,                // system clock
   input wire logic        rst,                    // async reset
   input wire logic [7:0]  reg_addr,               // register address
   input wire logic [31:0] reg_wdata,              // write data
   input wire logic        reg_wr,                 // write strobe
   input wire logic        reg_rd,                 // read strobe
   input wire logic [31:0] reg_rdata,              // read data
   input wire logic        external_trigger_input, // trigger pin
   input wire logic [15:0] level_out,              // applied level
   input wire logic        level_settled,          // settled flag
   input wire logic        sweep_active,           // sweep running
   input wire logic        freq_sweep_en,          // frequency sweep on
   input wire logic        list_en                 // list sequencing on
);
   logic [3:0]  ctl_q; // mirrored enable and mode
   logic [15:0] sta_q; // mirrored start level
   logic [15:0] stp_q; // mirrored stop level
   logic [15:0] inc_q; // mirrored step width
   logic [31:0] dw_q;  // mirrored dwell
   logic [31:0] cnt_q; // clocks since the last level change
   wire         wr_ctl = reg_wr && reg_addr == LSS_REG_CTRL; // ctrl write
   wire         wr_cmd = reg_wr && reg_addr == LSS_REG_CMD;  // cmd write
   wire  [31:0] dw_eff = (dw_q < 32'h2) ? 32'h2 : dw_q; // short dwell floor
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // shadow the registers so expectations do not lean on the design
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl_q <= 4'h0;
         sta_q <= LSS_RST_START;
         stp_q <= LSS_RST_STOP;
         inc_q <= LSS_RST_STEP;
         dw_q  <= LSS_RST_DWELL;
      end else if (reg_wr) begin
         if (reg_addr == LSS_REG_CTRL) ctl_q <= reg_wdata[3:0];
         if (reg_addr == LSS_REG_START) sta_q <= reg_wdata[15:0];
         if (reg_addr == LSS_REG_STOP) stp_q <= reg_wdata[15:0];
         if (reg_addr == LSS_REG_STEP) inc_q <= reg_wdata[15:0];
         if (reg_addr == LSS_REG_DWELL) dw_q <= reg_wdata;
      end
   end
   // the start of a run also restarts the count, level may already be start
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'h0;
      end else if (!sweep_active || $rose(sweep_active)
                   || $changed(level_out)) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end
   sequence s_step; // a timed step inside a running sweep
      sweep_active && $past(sweep_active) && $changed(level_out);
   endsequence
   sequence s_halt; // a mode change during a run to any mode but auto
      wr_ctl && sweep_active && reg_wdata[3:1] != ctl_q[3:1]
         && reg_wdata[3:1] != LSS_MODE_AUTO;
   endsequence
   AST_RD_CUR: assert property (reg_rd && reg_addr == LSS_REG_CUR |=>
      reg_rdata == {16'h0000, $past(level_out)}) else $error("bad level read");
   AST_EXCL: assert property (sweep_active |->
      !freq_sweep_en && !list_en) else $error("two sweeps at once");
   AST_EN_CLR: assert property (wr_ctl && reg_wdata[0] |=>
      !freq_sweep_en && !list_en) else $error("other sweeps not cleared");
   AST_RST_CMD: assert property (wr_cmd && reg_wdata[0] |=>
      level_out == sta_q) else $error("reset did not load start");
   AST_AUTO: assert property (wr_ctl && !ctl_q[0] && reg_wdata[0]
      && reg_wdata[3:1] == LSS_MODE_AUTO |-> ##2 sweep_active
      && level_out == sta_q)
      else $error("auto run did not start");
   AST_DWELL: assert property (s_step |-> cnt_q == dw_eff - 32'h1)
      else $error("step length differs from dwell");
   AST_WIDTH: assert property (s_step |->
      level_out == $past(level_out) + inc_q || level_out == stp_q
      || level_out == $past(level_out) - inc_q || level_out == sta_q)
      else $error("step is not one step width");
   AST_SETTLE: assert property (s_step |=>
      !level_settled || !sweep_active) else $error("settled too early");
   AST_HALT: assert property (s_halt |=>
      !sweep_active && $stable(level_out)) else $error("mode change kept run");
   AST_STEP_IDLE: assert property (ctl_q[3:1] == LSS_MODE_STEP |->
      !sweep_active) else $error("timed run in step mode");
endmodule : lss_monitor
bind lss_core lss_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .external_trigger_input(external_trigger_input), .level_out(level_out),
   .level_settled(level_settled), .sweep_active(sweep_active),
   .freq_sweep_en(freq_sweep_en), .list_en(list_en));

// file: lss_trig_src.sv
// external trigger source model: one long pulse per request
`timescale 1ns/1ps
module lss_trig_src #(
   parameter int PW = 8 // pulse width in clocks
) (
   input  wire logic clk_sys, // system clock
   input  wire logic rst,     // async reset
   input  wire logic fire,    // request one pulse
   output logic      pin      // trigger pin, idles low
);
   logic [7:0] cnt_q; // clocks left in the pulse
   // a wide pulse keeps its two edges apart so the active slope shows
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
      end else if (fire) begin
         cnt_q <= 8'(PW);
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign pin = (cnt_q != 8'h00); // high only inside a pulse
endmodule : lss_trig_src

// file: lss_core_tb_top.sv
// register-level testbench of the level sweep sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
   err_count++; $display("unexpected %s exp %0h got %0h", nm, exp, got); \
   end end
module lss_core_tb_top;
   import lss_pkg::*;
   logic        clk_sys, rst, reg_wr, reg_rd, fire; // clock, reset, strobes
   logic [7:0]  reg_addr;                           // register address
   logic [31:0] reg_wdata, reg_rdata, d;            // bus data
   logic [15:0] level_out;                          // applied level
   logic        settled, active, fsw, lst, trig;    // status and pin
   int          err_count, tests_run, cyc;          // counters
   lss_core u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .external_trigger_input(trig),
      .level_out(level_out), .level_settled(settled), .sweep_active(active),
      .freq_sweep_en(fsw), .list_en(lst));
   lss_trig_src u_src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .pin(trig));
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   // inputs move 1 ns after the edge, so they never race the design
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc_n
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      cyc_n(1);
      reg_wr <= 1'b0;
      cyc_n(1);
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc_n(1);
      reg_rd <= 1'b0;
      v = reg_rdata;
      cyc_n(1);
   endtask : rd
   task automatic pulse;
      fire <= 1'b1;
      cyc_n(1);
      fire <= 1'b0;
   endtask : pulse
   // bounded waits, a miss shows up as a mismatch
   task automatic wait_act(input logic v);
      for (int i = 0; i < 300 && active !== v; i++) cyc_n(1);
      `CHK("sweep_active", v, active)
   endtask : wait_act
   task automatic wait_lvl(input logic [15:0] v);
      for (int i = 0; i < 300 && level_out !== v; i++) cyc_n(1);
      `CHK("level_out", v, level_out)
   endtask : wait_lvl
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // hang guard well above the expected run length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   initial begin
      {rst, reg_wr, reg_rd, fire, reg_addr, reg_wdata} = '0;
      rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      cyc_n(1);
      `CHK("level_out", 16'hF830, level_out)
      rd(LSS_REG_STEP, d); `CHK("step", 32'h64, d)
      rd(LSS_REG_CUR, d); `CHK("cur", 32'hF830, d)
      rd(8'h20, d); `CHK("unmapped", 32'h0, d)
      wr(LSS_REG_START, 32'h0);
      wr(LSS_REG_STOP, 32'hC8);
      wr(LSS_REG_DWELL, 32'h4);
      wr(LSS_REG_CTRL, 32'h180); `CHK("fsw", 1'b1, fsw)
      wr(LSS_REG_CTRL, 32'h11); `CHK("fsw", 1'b0, fsw)
      `CHK("list_en", 1'b0, lst)
      `CHK("sweep_active", 1'b1, active)
      wait_lvl(16'hC8);
      cyc_n(6); `CHK("level_out", 16'h64, level_out)
      wait_lvl(16'h0);
      cyc_n(40); `CHK("sweep_active", 1'b1, active)
      wr(LSS_REG_CTRL, 32'h3); wr(LSS_REG_CMD, 32'h2);
      `CHK("sweep_active", 1'b1, active)
      `CHK("level_out", 16'h0, level_out)
      `CHK("level_settled", 1'b0, settled)
      wait_act(1'b0); `CHK("level_out", 16'hC8, level_out)
      cyc_n(20); `CHK("sweep_active", 1'b0, active)
      `CHK("level_settled", 1'b1, settled)
      wr(LSS_REG_CTRL, 32'h7); wr(LSS_REG_CMD, 32'h2);
      cyc_n(2); `CHK("sweep_active", 1'b0, active)
      pulse(); wait_act(1'b1);
      wait_act(1'b0); `CHK("level_out", 16'hC8, level_out)
      cyc_n(12); wr(LSS_REG_CTRL, 32'h27); pulse();
      cyc_n(4); `CHK("sweep_active", 1'b0, active)
      wait_act(1'b1);
      cyc_n(5); wr(LSS_REG_CTRL, 32'h9);
      `CHK("sweep_active", 1'b0, active)
      pulse(); cyc_n(12); `CHK("level_out", 16'h0, level_out)
      pulse(); cyc_n(12); `CHK("level_out", 16'h64, level_out)
      pulse(); cyc_n(12); `CHK("level_out", 16'hC8, level_out)
      wr(LSS_REG_CTRL, 32'hB); pulse(); wait_act(1'b1);
      cyc_n(12); pulse(); wait_act(1'b0);
      cyc_n(12); pulse(); wait_act(1'b1);
      `CHK("level_out", 16'h0, level_out)
      wr(LSS_REG_CMD, 32'h1); `CHK("level_out", 16'h0, level_out)
      wr(LSS_REG_CTRL, 32'h45); `CHK("sweep_active", 1'b0, active)
      `CHK("level_out", 16'h0, level_out)
      wr(LSS_REG_CUR, 32'h0); `CHK("level_out", 16'h64, level_out)
      wr(LSS_REG_CTRL, 32'h5); wr(LSS_REG_CUR, 32'hC8);
      `CHK("level_out", 16'hC8, level_out)
      wr(LSS_REG_CUR, 32'hC8); `CHK("level_out", 16'hC8, level_out)
      rd(LSS_REG_CUR, d); `CHK("cur", 32'hC8, d)
      rd(LSS_REG_CMD, d); `CHK("cmd", 32'h0, d)
      results();
   end
endmodule : lss_core_tb_top
